// ===== rtl/serial_channel_mode_sampler_consts.svh
/*
  Constants of the serial channel mode sampler: field widths, factors and reset values.
  Assumes inclusion by the package, the assertion module and the bench.
*/
`ifndef SERIAL_CHANNEL_MODE_SAMPLER_CONSTS_SVH
`define SERIAL_CHANNEL_MODE_SAMPLER_CONSTS_SVH

`define RATE_W 24
`define SYNTH_W 28
`define ERR_WIDTH_W 8
`define ERR_COUNT_W 32
`define OVERSAMPLE_FACTOR 28'h000000A
`define ASYNC_ERR_SAMPLES 8'h01
`define MIN_SYNC_ERR_BITS 8'h01
`define ERR_COUNT_RESET 32'h00000000
`define SYNTH_RESET 28'h0000000

`endif

// ===== rtl/serial_channel_mode_sampler_pkg.sv
/*
  Types of the serial channel mode sampler: timing choices, port roles, state structs.
  Assumes the constants header is on the include path.
*/
`include "serial_channel_mode_sampler_consts.svh"

package serial_channel_mode_sampler_pkg;

  typedef enum logic [4:0] {
    TIMING_SYNTH = 5'h01,
    TIMING_EXT = 5'h02,
    TIMING_FROM_DTE = 5'h04,
    TIMING_FROM_DCE = 5'h08,
    TIMING_SAMPLING = 5'h10
  } timing_e;

  typedef enum logic {
    ROLE_FACES_DTE = 1'b0,
    ROLE_FACES_DCE = 1'b1
  } role_e;

  // state of the system clock domain
  typedef struct packed {
    timing_e timing;
    logic [`SYNTH_W-1:0] synth_hz;
    role_e east_role;
    role_e west_role;
    logic req_tog;
    logic [`ERR_WIDTH_W-1:0] width;
    logic ack_s1;
    logic ack_s2;
    logic evt_s1;
    logic evt_s2;
    logic evt_prev;
    logic [`ERR_COUNT_W-1:0] err_count;
    logic link_rst_req;
    logic link_rst_ack_s1;
    logic link_rst_ack_s2;
  } sys_state_s;

  // state of the sampling clock domain
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic din_s1;
    logic din_s2;
    logic dout;
    logic async_s1;
    logic async_s2;
    logic req_s1;
    logic req_s2;
    logic ack_tog;
    logic [`ERR_WIDTH_W-1:0] err_left;
    logic evt_tog;
  } link_state_s;

endpackage : serial_channel_mode_sampler_pkg

// ===== rtl/serial_channel_mode_sampler.sv
/*
  Channel-side mode logic of a two-port serial simulator: mode selection, port roles,
  oversampled data path and error injection with event counting.
  Assumes sample_clk_i is the internal synthesizer output, programmed from synth_hz_o,
  and that it keeps running; a short rst_i still resets the link side through a handshake.
*/
// Summary of operation
// - async mode: synthesizer runs at ten times the configured baud rate.
// - async mode: each bit sampled about ten times, reproduced as the original bit.
// - oversampling jitter at most one tenth of a bit period.
// - rate input means baud in async mode, hertz in sync mode.
// - sync mode: error events span whole bits, at least one, single-bit steps.
// - async mode: each error event lasts one sample, a tenth of a bit.
// - async mode: error counter counts each tenth-of-a-bit event once.
// - East port always faces terminal equipment.
// - West port role selectable; terminal setting makes both ports face terminals.
// - communications setting: East faces terminal, West faces communications equipment.
// - async mode forces channel timing to sampling; other choices only in sync.
`timescale 1ns/100ps

module serial_channel_mode_sampler
  import serial_channel_mode_sampler_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic async_mode_i,
  input wire logic west_dce_i,
  input wire timing_e timing_sel_i,
  input wire logic [`RATE_W-1:0] rate_i,
  input wire logic err_inject_i,
  input wire logic [`ERR_WIDTH_W-1:0] err_width_i,
  input wire logic sample_clk_i,
  input wire logic data_in_i,
  output logic data_out_o,
  output timing_e timing_o,
  output logic [`SYNTH_W-1:0] synth_hz_o,
  output role_e east_role_o,
  output role_e west_role_o,
  output logic inject_busy_o,
  output logic [`ERR_COUNT_W-1:0] err_count_o
);

  sys_state_s s_q;
  sys_state_s s_d;
  link_state_s l_q;
  link_state_s l_d;
  logic busy;
  logic link_rst;

  // a request is outstanding until the link domain returns the toggle
  assign busy = s_q.req_tog != s_q.ack_s2;
  assign link_rst = l_q.rst_s2;

  always_comb
  begin
    s_d = s_q;
    if (async_mode_i)
    begin
      s_d.timing = TIMING_SAMPLING;
      s_d.synth_hz = `SYNTH_W'({4'h0, rate_i} * `OVERSAMPLE_FACTOR);
    end
    else
    begin
      // sampling is meaningless without async data, fall back to the synthesizer
      if (timing_sel_i == TIMING_SAMPLING)
      begin
        s_d.timing = TIMING_SYNTH;
      end
      else
      begin
        s_d.timing = timing_sel_i;
      end
      s_d.synth_hz = {4'h0, rate_i};
    end
    s_d.east_role = ROLE_FACES_DTE;
    if (west_dce_i)
    begin
      s_d.west_role = ROLE_FACES_DCE;
    end
    else
    begin
      s_d.west_role = ROLE_FACES_DTE;
    end
    // link reset stays requested until the link domain reports that it has seen it
    s_d.link_rst_ack_s1 = l_q.rst_s2;
    s_d.link_rst_ack_s2 = s_q.link_rst_ack_s1;
    if (s_q.link_rst_ack_s2)
    begin
      s_d.link_rst_req = 1'b0;
    end
    // link toggles are unknown until their reset lands, so they are masked meanwhile
    if (s_q.link_rst_req || s_q.link_rst_ack_s2)
    begin
      s_d.ack_s1 = 1'b0;
      s_d.evt_s1 = 1'b0;
    end
    else
    begin
      s_d.ack_s1 = l_q.ack_tog;
      s_d.evt_s1 = l_q.evt_tog;
    end
    s_d.ack_s2 = s_q.ack_s1;
    // width is held stable while the request toggle is in flight
    if (err_inject_i && !busy)
    begin
      s_d.req_tog = !s_q.req_tog;
      if (err_width_i < `MIN_SYNC_ERR_BITS)
      begin
        s_d.width = `MIN_SYNC_ERR_BITS;
      end
      else
      begin
        s_d.width = err_width_i;
      end
    end
    s_d.evt_s2 = s_q.evt_s1;
    s_d.evt_prev = s_q.evt_s2;
    if (s_q.evt_s2 != s_q.evt_prev)
    begin
      s_d.err_count = s_q.err_count + `ERR_COUNT_W'(1);
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      s_q.timing <= TIMING_SYNTH;
      s_q.synth_hz <= `SYNTH_RESET;
      s_q.east_role <= ROLE_FACES_DTE;
      s_q.west_role <= ROLE_FACES_DTE;
      s_q.req_tog <= 1'b0;
      s_q.width <= `MIN_SYNC_ERR_BITS;
      s_q.ack_s1 <= 1'b0;
      s_q.ack_s2 <= 1'b0;
      s_q.evt_s1 <= 1'b0;
      s_q.evt_s2 <= 1'b0;
      s_q.evt_prev <= 1'b0;
      s_q.err_count <= `ERR_COUNT_RESET;
      s_q.link_rst_req <= 1'b1;
      s_q.link_rst_ack_s1 <= 1'b0;
      s_q.link_rst_ack_s2 <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  always_comb
  begin
    l_d = l_q;
    // a reset shorter than a link period would be missed, so the held request is synced
    l_d.rst_s1 = s_q.link_rst_req;
    l_d.rst_s2 = l_q.rst_s1;
    // input has no companion clock, so it is treated as asynchronous
    l_d.din_s1 = data_in_i;
    l_d.din_s2 = l_q.din_s1;
    l_d.async_s1 = async_mode_i;
    l_d.async_s2 = l_q.async_s1;
    l_d.req_s1 = s_q.req_tog;
    l_d.req_s2 = l_q.req_s1;
    // one register per sample edge bounds jitter to one sample, a tenth of a bit
    l_d.dout = l_q.din_s2;
    if (l_q.err_left != `ERR_WIDTH_W'(0))
    begin
      l_d.dout = !l_q.din_s2;
      l_d.err_left = l_q.err_left - `ERR_WIDTH_W'(1);
    end
    if (l_q.req_s2 != l_q.ack_tog)
    begin
      l_d.ack_tog = l_q.req_s2;
      l_d.evt_tog = !l_q.evt_tog;
      if (l_q.async_s2)
      begin
        l_d.err_left = `ASYNC_ERR_SAMPLES;
      end
      else
      begin
        l_d.err_left = s_q.width;
      end
    end
  end

  // the reset synchroniser pair is outside the reset itself so it can clear
  always_ff @(posedge sample_clk_i)
  begin
    l_q.rst_s1 <= l_d.rst_s1;
    l_q.rst_s2 <= l_d.rst_s2;
    if (link_rst)
    begin
      l_q.din_s1 <= 1'b0;
      l_q.din_s2 <= 1'b0;
      l_q.dout <= 1'b0;
      l_q.async_s1 <= 1'b0;
      l_q.async_s2 <= 1'b0;
      l_q.req_s1 <= 1'b0;
      l_q.req_s2 <= 1'b0;
      l_q.ack_tog <= 1'b0;
      l_q.err_left <= `ERR_WIDTH_W'(0);
      l_q.evt_tog <= 1'b0;
    end
    else
    begin
      l_q.din_s1 <= l_d.din_s1;
      l_q.din_s2 <= l_d.din_s2;
      l_q.dout <= l_d.dout;
      l_q.async_s1 <= l_d.async_s1;
      l_q.async_s2 <= l_d.async_s2;
      l_q.req_s1 <= l_d.req_s1;
      l_q.req_s2 <= l_d.req_s2;
      l_q.ack_tog <= l_d.ack_tog;
      l_q.err_left <= l_d.err_left;
      l_q.evt_tog <= l_d.evt_tog;
    end
  end

  assign data_out_o = l_q.dout;
  assign timing_o = s_q.timing;
  assign synth_hz_o = s_q.synth_hz;
  assign east_role_o = s_q.east_role;
  assign west_role_o = s_q.west_role;
  assign err_count_o = s_q.err_count;

  // busy mirrors the toggle pair but must come from a flop of its own
  logic busy_q;
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= s_d.req_tog != s_d.ack_s2;
    end
  end
  assign inject_busy_o = busy_q;

endmodule : serial_channel_mode_sampler

// ===== bench/mode_sampler_sva.sv
/*
  Assertions on the mode sampler's system-side ports.
  Assumes a bind from the bench top; all checks run on clock_i.
*/
`timescale 1ns/100ps
`include "serial_channel_mode_sampler_consts.svh"
module mode_sampler_sva
  import serial_channel_mode_sampler_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic async_mode_i,
  input wire logic west_dce_i,
  input wire timing_e timing_sel_i,
  input wire logic [`RATE_W-1:0] rate_i,
  input wire logic err_inject_i,
  input wire logic inject_busy_o,
  input wire timing_e timing_o,
  input wire logic [`SYNTH_W-1:0] synth_hz_o,
  input wire role_e east_role_o,
  input wire role_e west_role_o,
  input wire logic [`ERR_COUNT_W-1:0] err_count_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  sequence s_take;
    err_inject_i && !inject_busy_o;
  endsequence
  // busy lasts the request toggle round trip through the slow link clock, whatever the width
  sequence s_done;
    inject_busy_o ##[1:400] !inject_busy_o;
  endsequence
  property p_east;
    east_role_o == ROLE_FACES_DTE;
  endproperty
  a_east: assert property (p_east) else $error("east role wrong");
  property p_west;
    1 |=> west_role_o == role_e'($past(west_dce_i));
  endproperty
  a_west: assert property (p_west) else $error("west role wrong");
  property p_atim;
    async_mode_i |=> timing_o == TIMING_SAMPLING;
  endproperty
  a_atim: assert property (p_atim) else $error("async timing wrong");
  property p_stim;
    !async_mode_i |=> timing_o == ($past(timing_sel_i) == TIMING_SAMPLING ? TIMING_SYNTH : $past(timing_sel_i));
  endproperty
  a_stim: assert property (p_stim) else $error("sync timing wrong");
  property p_arate;
    async_mode_i |=> synth_hz_o == $past(rate_i) * 28'h000000A;
  endproperty
  a_arate: assert property (p_arate) else $error("async rate wrong");
  property p_srate;
    !async_mode_i |=> synth_hz_o == $past(rate_i);
  endproperty
  a_srate: assert property (p_srate) else $error("sync rate wrong");
  property p_inj;
    s_take |=> s_done;
  endproperty
  a_inj: assert property (p_inj) else $error("inject handshake wrong");
  property p_cnt;
    $changed(err_count_o) |-> err_count_o == $past(err_count_o) + 32'h00000001;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count step wrong");
endmodule : mode_sampler_sva

// ===== bench/async_equipment.sv
/*
  Far-side equipment: low-speed data on a plain lead, no timing lead.
  Assumes bit edges never meet the link clock's edges (offset start).
*/
`timescale 1ns/100ps
module async_equipment
#(
  parameter real BIT_NS = 640.0
)
(
  output logic data_o
);
  logic [7:0] pat = 8'hB4;
  initial
  begin
    data_o = 1'h1;
    #5;
    forever
    begin
      data_o = pat[0];
      pat = {pat[6:0], pat[7] ^ pat[5]};
      #(BIT_NS);
    end
  end
endmodule : async_equipment

// ===== bench/tb_serial_channel_mode_sampler.sv
/*
  Self-checking bench: config table, oversampled data path, error injection.
  Assumes the partner drives data clocklessly at ten link samples per bit.
*/
`timescale 1ns/100ps
`include "serial_channel_mode_sampler_consts.svh"
module tb_serial_channel_mode_sampler;
  import serial_channel_mode_sampler_pkg::*;
  logic clock_i = 1'h0, rst_i = 1'h1, async_mode_i = 1'h0, west_dce_i = 1'h0, err_inject_i = 1'h0;
  logic sample_clk_i = 1'h0, data_in_i, data_out_o, inject_busy_o;
  logic [`RATE_W-1:0] rate_i = '0;
  logic [`ERR_WIDTH_W-1:0] err_width_i = '0;
  logic [`SYNTH_W-1:0] synth_hz_o;
  logic [`ERR_COUNT_W-1:0] err_count_o;
  timing_e timing_sel_i = TIMING_SYNTH, timing_o;
  role_e east_role_o, west_role_o;
  int err_count = 0, num_checks = 0, flips = 0, n;
  bit on = 0;
  logic [31:0] rs = 32'h00005D78;
  logic [34:0] cq[$];
  logic dq[$];
  serial_channel_mode_sampler dut (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .async_mode_i(async_mode_i),
    .west_dce_i(west_dce_i),
    .timing_sel_i(timing_sel_i),
    .rate_i(rate_i),
    .err_inject_i(err_inject_i),
    .err_width_i(err_width_i),
    .sample_clk_i(sample_clk_i),
    .data_in_i(data_in_i),
    .data_out_o(data_out_o),
    .timing_o(timing_o),
    .synth_hz_o(synth_hz_o),
    .east_role_o(east_role_o),
    .west_role_o(west_role_o),
    .inject_busy_o(inject_busy_o),
    .err_count_o(err_count_o)
  );
  async_equipment eq (.data_o(data_in_i));
  initial forever #2 clock_i = ~clock_i;
  initial
  begin
    #1.3;
    forever #32 sample_clk_i = ~sample_clk_i;
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : xs
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  always @(posedge clock_i)
    if (cq.size() > 0)
    begin
      #1;
      chk({timing_o, synth_hz_o, east_role_o, west_role_o}, cq.pop_front(), "config");
    end
  // settled output carries the input sampled two link edges earlier; a difference is an error sample
  always @(posedge sample_clk_i)
  begin
    #1;
    dq.push_back(data_in_i);
    if (dq.size() > 2 && dq.pop_front() !== data_out_o && on)
      flips++;
  end
  initial
  begin
    #40000;
    err_count++;
    end_of_test();
  end
  initial
  begin
    repeat (2) @(posedge clock_i);
    #0.5 rst_i = 1'h0;
    repeat (80) @(posedge clock_i);
    on = 1;
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clock_i);
      #0.5 async_mode_i = i[0];
      timing_sel_i = timing_e'(5'h01 << (i % 5));
      void'(xs());
      {rate_i, west_dce_i} = rs[24:0];
      cq.push_back({async_mode_i ? TIMING_SAMPLING : timing_sel_i == TIMING_SAMPLING ? TIMING_SYNTH : timing_sel_i,
        async_mode_i ? {4'h0, rate_i} * 28'h000000A : {4'h0, rate_i}, ROLE_FACES_DTE, west_dce_i});
      @(posedge clock_i);
    end
    repeat (300) @(posedge clock_i);
    chk(flips, 0, "data_path");
    $display("config done");
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clock_i);
      #0.5 async_mode_i = k[0];
      void'(xs());
      err_width_i = {6'h00, rs[1:0]};
      repeat (60) @(posedge clock_i);
      #0.5 flips = 0;
      // held over a second edge while busy: that request must be dropped
      err_inject_i = 1'h1;
      repeat (2) @(posedge clock_i);
      #0.5 err_inject_i = 1'h0;
      n = 0;
      while (inject_busy_o !== 1'h0 && n < 2000)
      begin
        @(posedge clock_i);
        n++;
      end
      chk(n < 2000, 1'b1, "busy_wait");
      repeat (300) @(posedge clock_i);
      chk(flips, k[0] ? 1 : (err_width_i == 0 ? 1 : err_width_i), "error_samples");
      chk(err_count_o, k + 1, "error_count");
      $display("inject %0d done", k);
    end
    end_of_test();
  end
endmodule : tb_serial_channel_mode_sampler
bind serial_channel_mode_sampler mode_sampler_sva sva_i (
  .clock_i(clock_i),
  .rst_i(rst_i),
  .async_mode_i(async_mode_i),
  .west_dce_i(west_dce_i),
  .timing_sel_i(timing_sel_i),
  .rate_i(rate_i),
  .err_inject_i(err_inject_i),
  .inject_busy_o(inject_busy_o),
  .timing_o(timing_o),
  .synth_hz_o(synth_hz_o),
  .east_role_o(east_role_o),
  .west_role_o(west_role_o),
  .err_count_o(err_count_o)
);
